/* File: shared/lsd_map.svh */
// Offsets, field positions, reset values and masks for the legacy region decoder.
// Assumes an 8-bit configuration offset and 8-bit configuration data.
`ifndef LSD_MAP_SVH
`define LSD_MAP_SVH

// ************************************************************
// Configuration offsets.
// ************************************************************
`define LSD_SEG_ATTR_BASE 8'h90
`define LSD_SEG_ATTR_LAST 8'h96
`define LSD_FIXED_HOLE_OFS 8'h97
`define LSD_DOS_HOLE_OFS 8'h9c
`define LSD_SMM_CTRL_OFS 8'h9d

// ************************************************************
// Field positions, masks and reset values.
// ************************************************************
`define LSD_HOLE_EN_BIT 7
`define LSD_DOS_HOLE_BIT 0
`define LSD_OPEN_BIT 6
`define LSD_CLOSED_BIT 5
`define LSD_LOCK_BIT 4
`define LSD_GEN_BIT 3
`define LSD_BASE_SEG 3'h2
`define LSD_SEG_ATTR_MASK 8'h33
`define LSD_SEG_ATTR0_MASK 8'h30
`define LSD_HOLE_MASK 8'h80
`define LSD_DOS_HOLE_MASK 8'h01
`define LSD_SMM_CTRL_RESET 8'h02

// ************************************************************
// Address ranges, as 32-bit byte addresses, and the 6-bit 16 KB segment index of C0000h.
// ************************************************************
`define LSD_LOW_LAST 32'h0007ffff
`define LSD_DOS_LAST 32'h0009ffff
`define LSD_VGA_LAST 32'h000bffff
`define LSD_EXP_LAST 32'h000effff
`define LSD_BIOS_LAST 32'h000fffff
`define LSD_HOLE_FIRST 32'h00f00000
`define LSD_HOLE_LAST 32'h00ffffff
`define LSD_EXP_SEG0 6'h30

`endif

/* File: shared/lsd_pkg.sv */
// Types shared by the legacy region decoder and its surroundings.
// Assumes the map header is compiled alongside for constants.
`default_nettype none
package lsd_pkg;

   // ************************************************************
   // Initiator and route encodings.
   // ************************************************************
   typedef enum logic [1:0] {LSD_SRC_HOST, LSD_SRC_HUB, LSD_SRC_AGP} lsd_src_t;

   typedef enum logic [2:0] {
      LSD_RT_MEM,
      LSD_RT_PCI,
      LSD_RT_AGP,
      LSD_RT_NONE,
      LSD_RT_REFUSE
   } lsd_route_t;

   // ************************************************************
   // Request and answer carriers.
   // ************************************************************
   typedef struct packed {
      logic [31:0] addr;
      logic write;
      lsd_src_t src;
      logic smm;
      logic code;
   } lsd_req_t;

   typedef struct packed {
      lsd_route_t route;
      logic [31:0] addr;
   } lsd_rsp_t;

endpackage
`default_nettype wire

/* File: rtl/lsd_decode.sv */
// Legacy region and compatible SMM_RAM_CONTROL decoder with its configuration registers.
// Assumes requests and configuration accesses come from logic on i_sys_clk.
//
// Operation
// - Lowest 512 KB always goes to memory.
// - 80000h-9FFFFh memory by default, hole optional.
// - Video range ignores attributes, follows VGA routing.
// - SMM video range refuses hub and AGP.
// - C0000h-DFFFFh: eight 16 KB attribute segments.
// - E0000h-EFFFFh: four 16 KB attribute segments.
// - F0000h-FFFFFh: one 64 KB attribute segment.
// - Hole enable sends 15-16 MB host cycles onward.
// - Hub cycles inside enabled hole not claimed.
// - Memory behind the hole is never relocated.
// - Open and closed act only with global enable; lock acts without it.
// - Open and unlocked exposes SMM space to all host cycles.
// - Closed blocks data, allows code, compatible only.
// - Lock clears open and freezes locked fields.
// - Lock set by write, cleared only by reset.
// - Read/write enables pick memory or PCI path for host cycles; hub and AGP cycles go to memory.
// - Global enable gives 128 KB SMM DRAM.
// - Base segment field hardwired to 010.
`timescale 1ns/10ps
`default_nettype none
`include "lsd_map.svh"

module lsd_decode #(
   parameter int SEG_REGS = 7
)(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_cfg_wr,
   input wire logic i_cfg_rd,
   input wire logic [7:0] i_cfg_addr,
   input wire logic [7:0] i_cfg_wdata,
   output logic [7:0] o_cfg_rdata,
   output logic o_cfg_rvalid,
   input wire logic i_vga_to_agp,
   input wire logic i_req_valid,
   input wire lsd_pkg::lsd_req_t i_req,
   output logic o_rsp_valid,
   output lsd_pkg::lsd_rsp_t o_rsp,
   output logic o_smm_locked
);

   // ************************************************************
   // Register state.
   // ************************************************************
   logic [7:0] seg_attr [SEG_REGS];
   logic [7:0] next_seg_attr [SEG_REGS];
   logic hole_enable;
   logic next_hole_enable;
   logic dos_hole;
   logic next_dos_hole;
   logic smm_space_open;
   logic next_smm_space_open;
   logic smm_space_closed;
   logic next_smm_space_closed;
   logic smm_space_locked;
   logic next_smm_space_locked;
   logic global_smm_ram_control_enable;
   logic next_global_smm_ram_control_enable;
   logic [7:0] next_cfg_rdata;
   logic next_cfg_rvalid;
   logic next_rsp_valid;
   lsd_pkg::lsd_rsp_t next_rsp;

   // ************************************************************
   // Helper functions.
   // ************************************************************

   // Returns the write and read enable pair for a C0000h-FFFFFh address.
   function automatic logic [1:0] seg_pair(input logic [31:0] addr,
                                           input logic [7:0] regs [SEG_REGS]);
      logic [5:0] idx;
      logic [2:0] reg_no;
      logic [1:0] pair;
      idx = addr[19:14] - `LSD_EXP_SEG0;
      reg_no = 3'(idx[5:1] + 5'h01);
      pair = 2'h0;
      if (addr > `LSD_EXP_LAST)
      begin
         pair = regs[0][5:4];
      end
      else if (idx[0])
      begin
         pair = regs[reg_no][5:4];
      end
      else
      begin
         pair = regs[reg_no][1:0];
      end
      return pair;
   endfunction

   // True when the offset addresses one of the attribute registers.
   function automatic logic is_seg_ofs(input logic [7:0] ofs);
      return (ofs >= `LSD_SEG_ATTR_BASE) && (ofs <= `LSD_SEG_ATTR_LAST);
   endfunction

   // ************************************************************
   // Configuration writes.
   // ************************************************************

   // Attribute registers keep only their defined enable bits.
   always_comb
   begin
      for (int i = 0; i < SEG_REGS; i++)
      begin
         next_seg_attr[i] = seg_attr[i];
      end
      if (i_cfg_wr && is_seg_ofs(i_cfg_addr))
      begin
         for (int i = 0; i < SEG_REGS; i++)
         begin
            if (i_cfg_addr == 8'(`LSD_SEG_ATTR_BASE + i))
            begin
               next_seg_attr[i] = i_cfg_wdata & ((i == 0) ? `LSD_SEG_ATTR0_MASK
                                                          : `LSD_SEG_ATTR_MASK);
            end
         end
      end
   end

   // Hole controls and the SMM control register.
   always_comb
   begin
      next_hole_enable = hole_enable;
      next_dos_hole = dos_hole;
      next_smm_space_open = smm_space_open;
      next_smm_space_closed = smm_space_closed;
      next_smm_space_locked = smm_space_locked;
      next_global_smm_ram_control_enable = global_smm_ram_control_enable;
      if (i_cfg_wr && (i_cfg_addr == `LSD_FIXED_HOLE_OFS))
      begin
         next_hole_enable = i_cfg_wdata[`LSD_HOLE_EN_BIT];
      end
      if (i_cfg_wr && (i_cfg_addr == `LSD_DOS_HOLE_OFS))
      begin
         next_dos_hole = i_cfg_wdata[`LSD_DOS_HOLE_BIT];
      end
      if (i_cfg_wr && (i_cfg_addr == `LSD_SMM_CTRL_OFS))
      begin
         next_smm_space_closed = i_cfg_wdata[`LSD_CLOSED_BIT];
         if (!smm_space_locked)
         begin
            next_smm_space_open = i_cfg_wdata[`LSD_OPEN_BIT];
            next_global_smm_ram_control_enable = i_cfg_wdata[`LSD_GEN_BIT];
            next_smm_space_locked = i_cfg_wdata[`LSD_LOCK_BIT];
         end
      end
      if (next_smm_space_locked)
      begin
         next_smm_space_open = 1'b0;
      end
   end

   // Register update; only reset clears the lock.
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         for (int i = 0; i < SEG_REGS; i++)
         begin
            seg_attr[i] <= 8'h00;
         end
         hole_enable <= 1'b0;
         dos_hole <= 1'b0;
         smm_space_open <= 1'b0;
         smm_space_closed <= 1'b0;
         smm_space_locked <= 1'b0;
         global_smm_ram_control_enable <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < SEG_REGS; i++)
         begin
            seg_attr[i] <= next_seg_attr[i];
         end
         hole_enable <= next_hole_enable;
         dos_hole <= next_dos_hole;
         smm_space_open <= next_smm_space_open;
         smm_space_closed <= next_smm_space_closed;
         smm_space_locked <= next_smm_space_locked;
         global_smm_ram_control_enable <= next_global_smm_ram_control_enable;
      end
   end

   // ************************************************************
   // Configuration reads.
   // ************************************************************

   // Read data is registered and answers one cycle after the strobe.
   always_comb
   begin
      next_cfg_rvalid = i_cfg_rd;
      next_cfg_rdata = 8'h00;
      if (i_cfg_rd)
      begin
         if (is_seg_ofs(i_cfg_addr))
         begin
            next_cfg_rdata = seg_attr[3'(i_cfg_addr - `LSD_SEG_ATTR_BASE)];
         end
         else if (i_cfg_addr == `LSD_FIXED_HOLE_OFS)
         begin
            next_cfg_rdata = {hole_enable, 7'h00};
         end
         else if (i_cfg_addr == `LSD_DOS_HOLE_OFS)
         begin
            next_cfg_rdata = {7'h00, dos_hole};
         end
         else if (i_cfg_addr == `LSD_SMM_CTRL_OFS)
         begin
            next_cfg_rdata = {1'b0, smm_space_open, smm_space_closed, smm_space_locked,
                              global_smm_ram_control_enable, `LSD_BASE_SEG};
         end
      end
   end

   // Read port registers.
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         o_cfg_rdata <= 8'h00;
         o_cfg_rvalid <= 1'b0;
      end
      else
      begin
         o_cfg_rdata <= next_cfg_rdata;
         o_cfg_rvalid <= next_cfg_rvalid;
      end
   end

   // ************************************************************
   // Address decode.
   // ************************************************************

   // Picks the route of one request from its address, initiator and mode.
   always_comb
   begin
      logic host;
      logic smm_visible;
      logic [1:0] pair;
      host = (i_req.src == lsd_pkg::LSD_SRC_HOST);
      smm_visible = global_smm_ram_control_enable &&
                    ((i_req.smm && !(smm_space_closed && !i_req.code)) ||
                     (smm_space_open && !smm_space_locked));
      pair = seg_pair(i_req.addr, seg_attr);
      next_rsp_valid = i_req_valid;
      next_rsp.addr = i_req.addr;
      next_rsp.route = lsd_pkg::LSD_RT_MEM;
      if (i_req.addr <= `LSD_LOW_LAST)
      begin
         next_rsp.route = lsd_pkg::LSD_RT_MEM;
      end
      else if (i_req.addr <= `LSD_DOS_LAST)
      begin
         next_rsp.route = dos_hole ? lsd_pkg::LSD_RT_PCI : lsd_pkg::LSD_RT_MEM;
      end
      else if (i_req.addr <= `LSD_VGA_LAST)
      begin
         if (!host)
         begin
            next_rsp.route = global_smm_ram_control_enable ? lsd_pkg::LSD_RT_REFUSE
                                                 : lsd_pkg::LSD_RT_NONE;
         end
         else if (smm_visible)
         begin
            next_rsp.route = lsd_pkg::LSD_RT_MEM;
         end
         else
         begin
            next_rsp.route = i_vga_to_agp ? lsd_pkg::LSD_RT_AGP : lsd_pkg::LSD_RT_PCI;
         end
      end
      else if (i_req.addr <= `LSD_BIOS_LAST)
      begin
         if (host)
         begin
            next_rsp.route = (i_req.write ? pair[1] : pair[0]) ? lsd_pkg::LSD_RT_MEM
                                                             : lsd_pkg::LSD_RT_PCI;
         end
      end
      else if ((i_req.addr >= `LSD_HOLE_FIRST) && (i_req.addr <= `LSD_HOLE_LAST) &&
               hole_enable)
      begin
         next_rsp.route = host ? lsd_pkg::LSD_RT_PCI : lsd_pkg::LSD_RT_NONE;
      end
   end

   // Answer registers; one answer per request, one cycle later.
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         o_rsp_valid <= 1'b0;
         o_rsp <= '{route: lsd_pkg::LSD_RT_MEM, addr: 32'h00000000};
         o_smm_locked <= 1'b0;
      end
      else
      begin
         o_rsp_valid <= next_rsp_valid;
         o_rsp <= next_rsp;
         o_smm_locked <= next_smm_space_locked;
      end
   end

endmodule

`default_nettype wire

/* File: testbench/lsd_decode_properties.sv */
// Checker for the legacy region decoder, watching its ports only.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module lsd_decode_chk (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_cfg_wr,
   input wire logic i_cfg_rd,
   input wire logic [7:0] i_cfg_addr,
   input wire logic [7:0] i_cfg_wdata,
   input wire logic [7:0] o_cfg_rdata,
   input wire logic o_cfg_rvalid,
   input wire logic i_vga_to_agp,
   input wire logic i_req_valid,
   input wire lsd_pkg::lsd_req_t i_req,
   input wire logic o_rsp_valid,
   input wire lsd_pkg::lsd_rsp_t o_rsp,
   input wire logic o_smm_locked
);
   // ************************************************************
   // Shadow of the hole and global enables.
   // ************************************************************
   logic hole;
   logic gen;
   logic next_hole;
   logic next_gen;
   logic host;
   assign host = (i_req.src == lsd_pkg::LSD_SRC_HOST);
   // Follows configuration writes; global enable freezes once locked.
   always_comb
   begin
      next_hole = (i_cfg_wr && i_cfg_addr == 8'h97) ? i_cfg_wdata[7] : hole;
      next_gen = (i_cfg_wr && i_cfg_addr == 8'h9d && !o_smm_locked) ? i_cfg_wdata[3] : gen;
   end
   // Registers the shadow bits.
   always_ff @(posedge i_sys_clk)
   begin
      hole <= i_rst_n & next_hole;
      gen <= i_rst_n & next_gen;
   end
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_lock_wr;
      i_cfg_wr && i_cfg_addr == 8'h9d && i_cfg_wdata[4];
   endsequence
   sequence s_hole_req;
      i_req_valid && hole && i_req.addr[31:20] == 12'h00f;
   endsequence
   property p_lock_set;
      s_lock_wr |=> o_smm_locked [*2];
   endproperty
   a_lock_set: assert property (p_lock_set) else $error("lock not held");
   property p_low;
      i_req_valid && i_req.addr <= 32'h7ffff |=> o_rsp.route == lsd_pkg::LSD_RT_MEM;
   endproperty
   a_low: assert property (p_low) else $error("low area not memory");
   property p_hub_hole;
      s_hole_req ##0 !host |=> o_rsp.route == lsd_pkg::LSD_RT_NONE;
   endproperty
   a_hub_hole: assert property (p_hub_hole) else $error("hub hole cycle claimed");
   property p_host_hole;
      s_hole_req ##0 host |=> o_rsp.route == lsd_pkg::LSD_RT_PCI;
   endproperty
   a_host_hole: assert property (p_host_hole) else $error("host hole not forwarded");
   property p_vga_other;
      i_req_valid && !host && i_req.addr[31:17] == 15'h5 |=>
         o_rsp.route == ($past(gen) ? lsd_pkg::LSD_RT_REFUSE : lsd_pkg::LSD_RT_NONE);
   endproperty
   a_vga_other: assert property (p_vga_other) else $error("video range not refused");
   property p_seg_other;
      i_req_valid && !host && i_req.addr[31:18] == 14'h3 |=> o_rsp.route == lsd_pkg::LSD_RT_MEM;
   endproperty
   a_seg_other: assert property (p_seg_other) else $error("segment not memory");
   property p_echo;
      i_req_valid |=> o_rsp_valid && o_rsp.addr == $past(i_req.addr);
   endproperty
   a_echo: assert property (p_echo) else $error("answer missing");
   property p_idle_rd;
      !i_cfg_rd |=> !o_cfg_rvalid && o_cfg_rdata == 8'h00;
   endproperty
   a_idle_rd: assert property (p_idle_rd) else $error("read data not idle");
   property p_base;
      i_cfg_rd && i_cfg_addr == 8'h9d |=> o_cfg_rvalid && o_cfg_rdata[2:0] == 3'h2;
   endproperty
   a_base: assert property (p_base) else $error("base segment wrong");
endmodule
bind lsd_decode lsd_decode_chk chk_u (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
   .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd), .i_cfg_addr(i_cfg_addr),
   .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata), .o_cfg_rvalid(o_cfg_rvalid),
   .i_vga_to_agp(i_vga_to_agp), .i_req_valid(i_req_valid), .i_req(i_req),
   .o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp), .o_smm_locked(o_smm_locked));
`default_nettype wire

/* File: testbench/lsd_host_model.sv */
// Requester model for host, hub and AGP cycles.
// Assumes the bench loads one request at a time.
`timescale 1ns/10ps
`default_nettype none
module lsd_host_model (
   input wire logic i_sys_clk,
   input wire logic i_load,
   input wire lsd_pkg::lsd_req_t i_next,
   output lsd_pkg::lsd_req_t o_req,
   output logic o_req_valid
);
   // Drives a request for one cycle; fields are scrambled while idle.
   always @(posedge i_sys_clk)
   begin
      o_req_valid <= i_load;
      o_req <= i_load ? i_next : ~i_next;
   end
endmodule
`default_nettype wire

/* File: testbench/legacy_region_smm_ram_control_decode_tb.sv */
// Self-checking bench for the legacy region decoder.
// Assumes the checker is bound to the decoder.
`timescale 1ns/10ps
`default_nettype none
module legacy_region_smm_ram_control_decode_tb;
   localparam lsd_pkg::lsd_route_t MEM = lsd_pkg::LSD_RT_MEM;
   localparam lsd_pkg::lsd_route_t PCI = lsd_pkg::LSD_RT_PCI;
   logic clk, rst_n, wr, rd, vga, load, rv, rsp_v, lckd, req_v;
   logic [7:0] addr, wdata, rdata;
   lsd_pkg::lsd_req_t nxt, req, q;
   lsd_pkg::lsd_rsp_t rsp;
   logic [7:0] attr [7];
   logic hole, dos, gen, opn, cls, lck;
   logic [31:0] base [6] = '{0, 32'h80000, 32'ha0000, 32'hc0000, 32'hf00000, 0};
   logic [31:0] mask [6] = '{32'h7ffff, 32'h1ffff, 32'h1ffff, 32'h3ffff, 32'hfffff, 32'hffffff};
   logic [31:0] r;
   logic [7:0] wd;
   int mismatches, tests_run, cycles, seed, i;
   lsd_decode dut_u (.i_sys_clk(clk), .i_rst_n(rst_n), .i_cfg_wr(wr), .i_cfg_rd(rd),
      .i_cfg_addr(addr), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata), .o_cfg_rvalid(rv),
      .i_vga_to_agp(vga), .i_req_valid(req_v), .i_req(req), .o_rsp_valid(rsp_v),
      .o_rsp(rsp), .o_smm_locked(lckd));
   lsd_host_model host_u (.i_sys_clk(clk), .i_load(load), .i_next(nxt), .o_req(req),
      .o_req_valid(req_v));
   // ************************************************************
   // Checking helpers.
   // ************************************************************
   task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask
   // Compares a decoded route.
   task automatic cmp_route(input string what, input lsd_pkg::lsd_route_t e,
                            input lsd_pkg::lsd_route_t g);
      tests_run++;
      if (g !== e)
      begin
         mismatches++;
         $display("Error %s expected %s seen %s", what, e.name(), g.name());
      end
   endtask
   // Compares a single status flag.
   task automatic cmp_flag(input string what, input logic e, input logic g);
      tests_run++;
      if (g !== e)
      begin
         mismatches++;
         $display("Error %s expected %b seen %b", what, e, g);
      end
   endtask
   task automatic wrap_up();
      if (mismatches == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Expected read value of a configuration offset.
   function automatic logic [7:0] reg_exp(input logic [7:0] a);
      if (a == 8'h97) return {hole, 7'h0};
      if (a == 8'h9c) return {7'h0, dos};
      if (a == 8'h9d) return {1'b0, opn, cls, lck, gen, 3'h2};
      return (a >= 8'h90 && a <= 8'h96) ? attr[a[2:0]] : 8'h00;
   endfunction
   // Expected route of a request under the shadow registers.
   function automatic lsd_pkg::lsd_route_t route_exp(input lsd_pkg::lsd_req_t x, input logic v);
      logic host;
      logic vis;
      logic [3:0] k;
      logic [3:0] n;
      host = (x.src == lsd_pkg::LSD_SRC_HOST);
      vis = gen & ((x.smm & !(cls & !x.code)) | (opn & !lck));
      k = x.addr[17:14];
      n = k[0] ? attr[k[3:1] + 3'h1][7:4] : attr[k[3:1] + 3'h1][3:0];
      if (x.addr >= 32'hf0000) n = attr[0][7:4];
      if (x.addr <= 32'h7ffff) return MEM;
      if (x.addr <= 32'h9ffff) return dos ? PCI : MEM;
      if (x.addr <= 32'hbffff)
         return !host ? (gen ? lsd_pkg::LSD_RT_REFUSE : lsd_pkg::LSD_RT_NONE)
            : vis ? MEM : v ? lsd_pkg::LSD_RT_AGP : PCI;
      if (x.addr <= 32'hfffff) return (!host || n[x.write]) ? MEM : PCI;
      if (x.addr[31:20] == 12'h00f && hole) return host ? PCI : lsd_pkg::LSD_RT_NONE;
      return MEM;
   endfunction
   // ************************************************************
   // Bus tasks.
   // ************************************************************
   task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      if (a >= 8'h90 && a <= 8'h96) attr[a[2:0]] = d & ((a == 8'h90) ? 8'h30 : 8'h33);
      if (a == 8'h97) hole = d[7];
      if (a == 8'h9c) dos = d[0];
      if (a == 8'h9d && !lck) {opn, lck, gen} = {d[6] & !d[4], d[4], d[3]};
      if (a == 8'h9d) cls = d[5];
   endtask
   task automatic cfg_rd(input logic [7:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      cmp_flag("rvalid", 1'b1, rv);
      cmp("rdata", reg_exp(a), rdata);
   endtask
   task automatic do_req(input lsd_pkg::lsd_req_t x, input logic v);
      @(posedge clk);
      load <= 1'b1;
      nxt <= x;
      vga <= v;
      @(posedge clk);
      load <= 1'b0;
      @(posedge clk);
      #1;
      cmp_route("route", route_exp(x, v), rsp.route);
   endtask
   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      {hole, dos, gen, opn, cls, lck} = '0;
      attr = '{default: 8'h00};
   endtask
   // Clock and cycle ceiling.
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         mismatches++;
         wrap_up();
      end
   end
   // Main sequence: reset values, random traffic, then the lock walk.
   initial
   begin
      {rst_n, wr, rd, vga, load} = '0;
      addr = 8'h00;
      wdata = 8'h00;
      nxt = '0;
      seed = 85;
      do_reset();
      cfg_rd(8'h9d);
      cfg_wr(8'h97, 8'hff);
      cfg_rd(8'h97);
      q = {32'h00f80000, 1'b0, lsd_pkg::LSD_SRC_HUB, 1'b0, 1'b0};
      do_req(q, 1'b0);
      q.src = lsd_pkg::LSD_SRC_HOST;
      do_req(q, 1'b0);
      for (i = 0; i < 400; i++)
      begin
         r = $random(seed);
         if (r[7:5] == 3'h0)
         begin
            wd = r[23:16] & ((r[11:8] == 4'hd) ? 8'hef : 8'hff);
            if (wd[6]) wd[5] = 1'b0;
            cfg_wr(8'h90 + {4'h0, r[11:8]}, wd);
            cfg_rd(8'h90 + {4'h0, r[11:8]});
         end
         q.addr = base[r[14:12] % 6] | ($random(seed) & mask[r[14:12] % 6]);
         q.write = r[0];
         q.smm = r[1];
         q.code = r[2];
         q.src = r[4] ? lsd_pkg::LSD_SRC_HOST : r[3] ? lsd_pkg::LSD_SRC_HUB : lsd_pkg::LSD_SRC_AGP;
         do_req(q, r[15]);
      end
      do_reset();
      cfg_wr(8'h9d, 8'h48);
      q = {32'ha0000, 1'b0, lsd_pkg::LSD_SRC_HOST, 1'b0, 1'b0};
      do_req(q, 1'b0);
      cfg_wr(8'h9d, 8'h08);
      cfg_wr(8'h9d, 8'h18);
      cfg_rd(8'h9d);
      cmp_flag("locked", 1'b1, lckd);
      do_req(q, 1'b1);
      cfg_wr(8'h9d, 8'h40);
      cfg_rd(8'h9d);
      do_req(q, 1'b0);
      cfg_wr(8'h9d, 8'h20);
      cfg_rd(8'h9d);
      q.smm = 1'b1;
      do_req(q, 1'b0);
      q.code = 1'b1;
      do_req(q, 1'b0);
      q.src = lsd_pkg::LSD_SRC_HUB;
      do_req(q, 1'b0);
      wrap_up();
   end
endmodule
`default_nettype wire
